// *** verilog/gpw_channel.sv ***
/*
 * gated pwm output channel: gates, on-delay, pulse train, minimum pulse, manual output.
 * assumes synchronous inputs, one 40 MHz clock, sub-blocks gpw_tick and gpw_job.
 */
// Operation
// - software gate opens on rising request edge, closes when request falls
// - internal gate is software gate AND latched hardware start, shown on status output
// - gate enable starts on-delay, then pulse train repeats while enabled
// - software gate alone starts and stops modulation
// - with both gates, start only on hardware rising edge while software open
// - with both gates, stop only on software gate falling edge
// - pulse width is duty over 1000 or 27648 times period
// - duty changes apply at once, reshaping the current period
// - period is base times count, at least twice minimum pulse
// - period changes apply at once, giving one transitional period
// - on-delay is base times count, from sequence start to first pulse
// - on-delay changes apply at once during the on-delay, else at next start
// - phases shorter than minimum pulse width are suppressed
// - minimum change while low: go high if low phase already too short
// - minimum change while high: go low if pulse already too short
// - accepted ranges of period and minimum pulse per time base; on-delay written without range check
// - time base 0.1 ms or 1 ms sets counter resolution
// - manual select makes output follow manual level, else pulse train
// - hardware gate opening with software gate closed raises event, if enabled
// - job error sets job fault flag and cause code
// - bad mode clears block ok flag and reports cause code
// - duty above format maximum is clamped
// - job launched on trigger rise, idle drops one cycle
`timescale 1ns/1ps
`default_nettype none
`include "gpw_defs.svh"

module gpw_channel (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 soft_gate_request_in,
  input  wire logic                 hw_gate_in,
  input  wire logic                 hw_gate_used_in,
  input  wire gpw_pkg::gpw_tb_e     tb_sel_in,
  input  wire gpw_pkg::gpw_fmt_e    fmt_sel_in,
  input  wire logic                 mode_valid_in,
  input  wire logic                 manual_output_select_in,
  input  wire logic                 manual_level_in,
  input  wire logic [15:0]          duty_value_in,
  input  wire logic                 hw_event_enable_in,
  input  wire logic                 job_trig_in,
  input  wire gpw_pkg::gpw_job_s    job_in,
  output gpw_pkg::gpw_job_ans_s     job_ans_out,
  output logic                      internal_gate_status_out,
  output logic                      hw_gate_status_out,
  output logic                      pwm_out,
  output logic                      hw_event_out,
  output logic                      block_ok_flag_out,
  output logic [15:0]               sys_fault_code_out
);
  import gpw_pkg::*;

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  logic         tick;
  logic [15:0]  per, dly, minp;

  gpw_tick u_tick (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .tb_sel_in  (tb_sel_in),
    .tick_out   (tick)
  );

  gpw_job u_job (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .job_trig_in (job_trig_in),
    .job_in      (job_in),
    .tb_sel_in   (tb_sel_in),
    .ans_out     (job_ans_out),
    .period_out  (per),
    .delay_out   (dly),
    .minp_out    (minp)
  );

  // ---------------------------------------------------------------
  // gating
  // ---------------------------------------------------------------
  logic sw_req_d_r, sw_gate_r, sw_gate_nxt;
  logic hw_d_r, run_r, run_nxt, evt_r, evt_nxt;
  logic sw_rise, sw_fall, hw_rise;

  always_comb begin
    sw_rise = soft_gate_request_in && !sw_req_d_r;
    sw_fall = !soft_gate_request_in && sw_req_d_r;
    hw_rise = hw_gate_in && !hw_d_r;
    sw_gate_nxt = sw_gate_r;
    if (sw_rise && mode_valid_in) begin
      sw_gate_nxt = 1'b1;
    end else if (!soft_gate_request_in) begin
      sw_gate_nxt = 1'b0;
    end
    run_nxt = run_r;
    if (!hw_gate_used_in) begin
      run_nxt = sw_gate_nxt;
    end else if (sw_fall || !sw_gate_nxt) begin
      run_nxt = 1'b0;
    end else if (hw_rise && sw_gate_r) begin
      run_nxt = 1'b1;
    end
    evt_nxt = hw_event_enable_in && hw_gate_used_in && hw_rise && !sw_gate_r;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sw_req_d_r <= 1'b0;
      sw_gate_r  <= 1'b0;
      hw_d_r     <= 1'b0;
      run_r      <= 1'b0;
      evt_r      <= 1'b0;
    end else begin
      sw_req_d_r <= soft_gate_request_in;
      sw_gate_r  <= sw_gate_nxt;
      hw_d_r     <= hw_gate_in;
      run_r      <= run_nxt;
      evt_r      <= evt_nxt;
    end
  end

  // internal gate: hardware part is the latched start when the input is used
  assign internal_gate_status_out = run_r;
  assign hw_gate_status_out       = hw_gate_in;
  assign hw_event_out             = evt_r;

  // ---------------------------------------------------------------
  // pulse width
  // ---------------------------------------------------------------
  logic [15:0] duty_c;
  logic [15:0] full_c;
  logic [31:0] prod;
  logic [15:0] hi_units;

  always_comb begin
    full_c = (fmt_sel_in == GPW_FMT_ANALOG) ? `GPW_DUTY_ANALOG : `GPW_DUTY_PERMIL;
    duty_c = (duty_value_in > full_c) ? full_c : duty_value_in;
    prod   = {16'h0000, duty_c} * {16'h0000, per};
    hi_units = 16'(prod / {16'h0000, full_c});
  end

  // ---------------------------------------------------------------
  // waveform sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {GPW_ST_IDLE, GPW_ST_DELAY, GPW_ST_HIGH, GPW_ST_LOW} gpw_state_e;

  gpw_state_e  st_r, st_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;   // units into current period or delay
  logic [15:0] ph_r, ph_nxt;       // units into current phase
  logic [15:0] mp_prev_r;
  logic        out_r, out_nxt;
  logic        minp_chg;
  logic [15:0] mp_eff;
  logic        short_ok;

  always_comb begin
    // 0 at the slow base means 0.2 ms, i.e. effectively one unit floor
    mp_eff   = (minp == 16'h0000) ? 16'h0001 : minp;
    minp_chg = (minp != mp_prev_r);
    st_nxt   = st_r;
    pcnt_nxt = pcnt_r;
    ph_nxt   = ph_r;
    short_ok = 1'b1;
    case (st_r)
      GPW_ST_IDLE: begin
        pcnt_nxt = 16'h0000;
        ph_nxt   = 16'h0000;
        if (run_r) begin
          st_nxt = GPW_ST_DELAY;
        end
      end
      GPW_ST_DELAY: begin
        if (tick) begin
          pcnt_nxt = pcnt_r + 16'h0001;
        end
        if (pcnt_r >= dly) begin
          st_nxt   = (hi_units >= mp_eff) ? GPW_ST_HIGH : GPW_ST_LOW;
          pcnt_nxt = 16'h0000;
          ph_nxt   = 16'h0000;
        end
      end
      GPW_ST_HIGH: begin
        if (tick) begin
          pcnt_nxt = pcnt_r + 16'h0001;
          ph_nxt   = ph_r + 16'h0001;
        end
        if (minp_chg && ph_r < minp) begin
          st_nxt = GPW_ST_LOW;
          ph_nxt = 16'h0000;
        end else if (pcnt_r >= hi_units || hi_units < mp_eff) begin
          short_ok = (per - hi_units) >= mp_eff;
          if (ph_r >= mp_eff) begin
            st_nxt = short_ok ? GPW_ST_LOW : GPW_ST_HIGH;
            ph_nxt = short_ok ? 16'h0000 : ph_nxt;
            if (!short_ok && pcnt_r >= per) begin
              pcnt_nxt = 16'h0000;
            end
          end
        end
      end
      GPW_ST_LOW: begin
        if (tick) begin
          pcnt_nxt = pcnt_r + 16'h0001;
          ph_nxt   = ph_r + 16'h0001;
        end
        if (minp_chg && ph_r < minp) begin
          st_nxt   = GPW_ST_HIGH;
          pcnt_nxt = 16'h0000;
          ph_nxt   = 16'h0000;
        end else if (pcnt_r >= per && (ph_r >= mp_eff || hi_units < mp_eff)) begin
          pcnt_nxt = 16'h0000;
          if (hi_units >= mp_eff) begin
            st_nxt = GPW_ST_HIGH;
            ph_nxt = 16'h0000;
          end
        end
      end
      default: st_nxt = GPW_ST_IDLE;
    endcase
    if (!run_r) begin
      st_nxt   = GPW_ST_IDLE;
      pcnt_nxt = 16'h0000;
      ph_nxt   = 16'h0000;
    end
    if (manual_output_select_in) begin
      out_nxt = manual_level_in;
    end else begin
      out_nxt = (st_nxt == GPW_ST_HIGH);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_r      <= GPW_ST_IDLE;
      pcnt_r    <= 16'h0000;
      ph_r      <= 16'h0000;
      mp_prev_r <= `GPW_RST_MINP;
      out_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      pcnt_r    <= pcnt_nxt;
      ph_r      <= ph_nxt;
      mp_prev_r <= minp;
      out_r     <= out_nxt;
    end
  end

  assign pwm_out = out_r;

  // ---------------------------------------------------------------
  // system error
  // ---------------------------------------------------------------
  logic        ok_r, ok_nxt;
  logic [15:0] sc_r, sc_nxt;

  always_comb begin
    ok_nxt = mode_valid_in;
    sc_nxt = mode_valid_in ? `GPW_ERR_NONE : `GPW_ERR_MODE;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ok_r <= 1'b1;
      sc_r <= `GPW_ERR_NONE;
    end else begin
      ok_r <= ok_nxt;
      sc_r <= sc_nxt;
    end
  end

  assign block_ok_flag_out  = ok_r;
  assign sys_fault_code_out = sc_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_sw_fall;
    sw_req_d_r && !soft_gate_request_in;
  endsequence

  a_sw_gate_close: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_sw_fall |=> !sw_gate_r)
    else $error("software gate did not close");
  a_stop_sw_fall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_sw_fall |=> !run_r)
    else $error("run did not stop on soft gate fall");
  a_start_hw_rise: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $past(hw_gate_used_in) && $rose(run_r) |-> $past(hw_gate_in) && !$past(hw_d_r))
    else $error("start without hardware edge");
  a_idle_out_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !run_r && !manual_output_select_in |=> !manual_output_select_in |-> !out_r)
    else $error("output high while gate closed");
  a_manual_follow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    manual_output_select_in |=> out_r == $past(manual_level_in))
    else $error("manual level not followed");
  a_hw_event_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    hw_event_out |-> $past(hw_event_enable_in) && !$past(sw_gate_r) && $past(hw_gate_in))
    else $error("event without cause");
  a_gate_delay_first: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st_r == GPW_ST_IDLE && run_r |=> st_r == GPW_ST_DELAY)
    else $error("on-delay not started");
  a_ok_mode: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !mode_valid_in |=> !block_ok_flag_out && sys_fault_code_out == `GPW_ERR_MODE)
    else $error("mode error not reported");

endmodule : gpw_channel
`default_nettype wire

// *** verilog/gpw_defs.svh ***
/*
 * constants for the gated pwm channel: time base, job codes, limits, fault codes.
 * assumes a 40 MHz system clock.
 */
`ifndef GPW_DEFS_SVH
`define GPW_DEFS_SVH

`define GPW_CLK_HZ        40000000
`define GPW_TB_FAST_NS    100000
`define GPW_TB_SLOW_NS    1000000
`define GPW_TB_FAST_CYC   ((`GPW_CLK_HZ / 1000) * (`GPW_TB_FAST_NS / 1000) / 1000)
`define GPW_TB_SLOW_CYC   ((`GPW_CLK_HZ / 1000) * (`GPW_TB_SLOW_NS / 1000) / 1000)
`define GPW_MINP_ZERO_NS  200000
`define GPW_MINP_ZERO_CYC ((`GPW_CLK_HZ / 1000) * (`GPW_MINP_ZERO_NS / 1000) / 1000)
`define GPW_DUTY_PERMIL   16'h03E8
`define GPW_DUTY_ANALOG   16'h6C00
`define GPW_JOB_NONE      8'h00
`define GPW_JOB_WR_PER    8'h01
`define GPW_JOB_WR_DLY    8'h02
`define GPW_JOB_WR_MINP   8'h04
`define GPW_JOB_RD_PER    8'h81
`define GPW_JOB_RD_DLY    8'h82
`define GPW_JOB_RD_MINP   8'h83
`define GPW_RST_PER       16'h000A
`define GPW_RST_DLY       16'h0000
`define GPW_RST_MINP      16'h0002
`define GPW_ERR_NONE      16'h0000
`define GPW_ERR_JOB_ID    16'h0001
`define GPW_ERR_PER_RNG   16'h0002
`define GPW_ERR_MINP_RNG  16'h0003
`define GPW_ERR_MODE      16'h0010

`endif

// *** verilog/gpw_pkg.sv ***
/*
 * types shared by the gated pwm channel.
 * assumes gpw_defs.svh supplies the numbers.
 */
package gpw_pkg;

  typedef struct packed {
    logic        valid;
    logic [7:0]  job_id;
    logic [15:0] value;
  } gpw_job_s;

  typedef struct packed {
    logic        idle;
    logic        fault;
    logic [15:0] code;
    logic [15:0] read_value;
  } gpw_job_ans_s;

  typedef enum logic {GPW_TB_FAST, GPW_TB_SLOW} gpw_tb_e;
  typedef enum logic {GPW_FMT_PERMIL, GPW_FMT_ANALOG} gpw_fmt_e;

endpackage : gpw_pkg

// *** verilog/gpw_tick.sv ***
/*
 * time base divider: one-cycle tick per time base unit.
 * assumes synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpw_defs.svh"

module gpw_tick (
  input  wire logic          sys_clk_in,
  input  wire logic          reset_in,
  input  wire gpw_pkg::gpw_tb_e tb_sel_in,
  output logic               tick_out
);
  import gpw_pkg::*;

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] lim;

  always_comb begin
    lim = (tb_sel_in == GPW_TB_SLOW) ? 16'(`GPW_TB_SLOW_CYC - 1) : 16'(`GPW_TB_FAST_CYC - 1);
    cnt_nxt = (cnt_r >= lim) ? 16'h0000 : cnt_r + 16'h0001;
    tick_out = (cnt_r >= lim);
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : gpw_tick
`default_nettype wire

// *** verilog/gpw_job.sv ***
/*
 * job interface: edge-launched writes and reads of period, on-delay, minimum pulse.
 * assumes the caller waits for idle before a new trigger.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpw_defs.svh"

module gpw_job (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              job_trig_in,
  input  wire gpw_pkg::gpw_job_s  job_in,
  input  wire gpw_pkg::gpw_tb_e   tb_sel_in,
  output gpw_pkg::gpw_job_ans_s  ans_out,
  output logic [15:0]            period_out,
  output logic [15:0]            delay_out,
  output logic [15:0]            minp_out
);
  import gpw_pkg::*;

  logic         trig_d_r;
  gpw_job_ans_s ans_r, ans_nxt;
  logic [15:0]  per_r, per_nxt, dly_r, dly_nxt, mp_r, mp_nxt;
  logic [15:0]  per_min;
  logic [15:0]  mp_min;

  always_comb begin
    ans_nxt = ans_r;
    per_nxt = per_r;
    dly_nxt = dly_r;
    mp_nxt  = mp_r;
    per_min = (tb_sel_in == GPW_TB_FAST) ? 16'h0004 : 16'h0001;
    mp_min  = (tb_sel_in == GPW_TB_FAST) ? 16'h0002 : 16'h0000;
    ans_nxt.idle = 1'b1;
    if (job_trig_in && !trig_d_r) begin
      ans_nxt.idle  = 1'b0;
      ans_nxt.fault = 1'b0;
      ans_nxt.code  = `GPW_ERR_NONE;
      case (job_in.job_id)
        `GPW_JOB_NONE: ;
        `GPW_JOB_WR_PER: begin
          if (job_in.value < per_min || {1'b0, job_in.value} < {mp_r, 1'b0}) begin
            ans_nxt.fault = 1'b1;
            ans_nxt.code  = `GPW_ERR_PER_RNG;
          end else begin
            per_nxt = job_in.value;
          end
        end
        `GPW_JOB_WR_DLY: dly_nxt = job_in.value;
        `GPW_JOB_WR_MINP: begin
          if (job_in.value < mp_min || {job_in.value, 1'b0} > {1'b0, per_r}) begin
            ans_nxt.fault = 1'b1;
            ans_nxt.code  = `GPW_ERR_MINP_RNG;
          end else begin
            mp_nxt = job_in.value;
          end
        end
        `GPW_JOB_RD_PER:  ans_nxt.read_value = per_r;
        `GPW_JOB_RD_DLY:  ans_nxt.read_value = dly_r;
        `GPW_JOB_RD_MINP: ans_nxt.read_value = mp_r;
        default: begin
          ans_nxt.fault = 1'b1;
          ans_nxt.code  = `GPW_ERR_JOB_ID;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      trig_d_r <= 1'b0;
      ans_r    <= '{idle: 1'b1, fault: 1'b0, code: `GPW_ERR_NONE, read_value: 16'h0000};
      per_r    <= `GPW_RST_PER;
      dly_r    <= `GPW_RST_DLY;
      mp_r     <= `GPW_RST_MINP;
    end else begin
      trig_d_r <= job_trig_in;
      ans_r    <= ans_nxt;
      per_r    <= per_nxt;
      dly_r    <= dly_nxt;
      mp_r     <= mp_nxt;
    end
  end

  assign ans_out    = ans_r;
  assign period_out = per_r;
  assign delay_out  = dly_r;
  assign minp_out   = mp_r;

  a_job_idle_drop: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    job_trig_in && !trig_d_r |=> !ans_r.idle ##1 ans_r.idle)
    else $error("idle did not drop for one cycle");

endmodule : gpw_job
`default_nettype wire

// *** tb/gpw_load.sv ***
/*
 * actuator load on the pwm pin: times each high and low phase in clock cycles.
 * assumes the pin is sampled on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module gpw_load (
  input  wire logic sys_clk_in,
  input  wire logic drive_in,
  output var  int   hi_w_out,
  output var  int   lo_w_out,
  output var  int   edges_out
);
  int   run_r = 0;
  logic lvl_r = 1'b0;

  // ----------------------------------------
  // phase timer
  // ----------------------------------------
  initial begin
    hi_w_out = 0;
    lo_w_out = 0;
    edges_out = 0;
  end

  always @(posedge sys_clk_in) begin
    if (drive_in !== lvl_r) begin
      if (lvl_r) begin
        hi_w_out <= run_r;
      end else begin
        lo_w_out <= run_r;
      end
      edges_out <= edges_out + 1;
      run_r <= 1;
      lvl_r <= drive_in;
    end else begin
      run_r <= run_r + 1;
    end
  end
endmodule : gpw_load

`default_nettype wire

// *** tb/gated_pwm_output_channel_tb.sv ***
/*
 * self-checking bench for gpw_channel with a load model on the pin.
 * assumes the fast time base is 4000 cycles of the 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpw_defs.svh"

module gated_pwm_output_channel_tb;
  import gpw_pkg::*;
  localparam int TBC = 4000;
  logic         sys_clk_in = 1'b0;
  logic         reset_in   = 1'b1;
  logic         sg, hg, hgu, mv, ms, ml, ev_en, jt;
  gpw_tb_e      tbs;
  gpw_fmt_e     fmt;
  logic [15:0]  duty, sfc;
  gpw_job_s     job;
  gpw_job_ans_s ans;
  logic         igs, hgs, pwm, hev, ok, acc;
  int           hi_w, lo_w, edges, waited, e0, i;
  int           n_fail = 0;
  int           num_checks = 0;
  int           cyc = 0;
  logic [31:0]  rng = 32'd59;
  logic [31:0]  r;
  logic [7:0]   bad;
  logic [7:0]   rid [3] = '{`GPW_JOB_RD_PER, `GPW_JOB_RD_DLY, `GPW_JOB_RD_MINP};
  logic [15:0]  rv [3] = '{`GPW_RST_PER, `GPW_RST_DLY, `GPW_RST_MINP};

  always #12.5 sys_clk_in = ~sys_clk_in;

  gpw_channel DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .soft_gate_request_in(sg),
    .hw_gate_in(hg), .hw_gate_used_in(hgu), .tb_sel_in(tbs), .fmt_sel_in(fmt), .mode_valid_in(mv),
    .manual_output_select_in(ms), .manual_level_in(ml), .duty_value_in(duty),
    .hw_event_enable_in(ev_en), .job_trig_in(jt), .job_in(job), .job_ans_out(ans),
    .internal_gate_status_out(igs), .hw_gate_status_out(hgs), .pwm_out(pwm),
    .hw_event_out(hev), .block_ok_flag_out(ok), .sys_fault_code_out(sfc));

  gpw_load u_load (.sys_clk_in(sys_clk_in), .drive_in(pwm), .hi_w_out(hi_w), .lo_w_out(lo_w),
    .edges_out(edges));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tk(input int n = 1);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tk

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic int pw(input int d, input int den, input int per);
    if (d > den) d = den;
    return d * per / den * TBC;
  endfunction : pw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkw(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR t=%0t width %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chkw

  function automatic logic pick(input int w);
    case (w)
      0: return igs;
      1: return pwm;
      2: return hev;
      default: return ans.idle;
    endcase
  endfunction : pick

  task automatic wt(input int w, input logic v, input int lim);
    waited = 0;
    while (pick(w) !== v && waited < lim) begin
      tk();
      waited++;
    end
    chk({15'h0, pick(w)}, {15'h0, v});
  endtask : wt

  task automatic wed(input int lim);
    int e;
    e = edges;
    waited = 0;
    while (edges == e && waited < lim) begin
      tk();
      waited++;
    end
    chkw(waited, 1, lim - 1);
  endtask : wed

  task automatic do_job(input logic [7:0] id, input logic [15:0] v, input logic [15:0] code);
    job = '{1'b1, id, v};
    jt = 1'b1;
    tk();
    jt = 1'b0;
    wt(3, 1'b0, 4);
    tk();
    chk({15'h0, ans.idle}, 16'h0001);
    chk({15'h0, ans.fault}, {15'h0, code != 16'h0});
    chk(ans.code, code);
  endtask : do_job

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc >= 96000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sg, hg, hgu, ms, ml, ev_en, jt} = 7'h00;
    mv = 1'b1;
    tbs = GPW_TB_FAST;
    fmt = GPW_FMT_PERMIL;
    duty = 16'h01F4;
    job = '0;
    tk(3);
    reset_in = 1'b0;
    tk();
    chk({12'h0, igs, pwm, hev, ok}, 16'h0001);
    chk(sfc, `GPW_ERR_NONE);
    for (i = 0; i < 3; i++) begin
      do_job(rid[i], 16'h0, `GPW_ERR_NONE);
      chk(ans.read_value, rv[i]);
    end
    do_job(`GPW_JOB_WR_PER, 16'h0003, `GPW_ERR_PER_RNG);
    do_job(`GPW_JOB_WR_PER, 16'h0004, `GPW_ERR_NONE);
    do_job(`GPW_JOB_WR_MINP, 16'h0001, `GPW_ERR_MINP_RNG);
    do_job(`GPW_JOB_WR_MINP, 16'h0003, `GPW_ERR_MINP_RNG);
    do_job(`GPW_JOB_WR_DLY, 16'h0002, `GPW_ERR_NONE);
    bad = 8'h00;
    while (bad inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h81, 8'h82, 8'h83}) begin
      r = xs();
      bad = r[7:0];
    end
    do_job(bad, 16'h0005, `GPW_ERR_JOB_ID);
    do_job(`GPW_JOB_RD_PER, 16'h0, `GPW_ERR_NONE);
    chk(ans.read_value, 16'h0004);
    // manual output
    ms = 1'b1;
    for (i = 0; i < 8; i++) begin
      r = xs();
      ml = r[0];
      tk(2);
      chk({15'h0, pwm}, {15'h0, ml});
    end
    ms = 1'b0;
    // hardware event
    {hgu, ev_en, hg} = 3'b111;
    #1;
    chk({15'h0, hgs}, 16'h0001);
    wt(2, 1'b1, 3);
    tk();
    chk({15'h0, hev}, 16'h0000);
    {ev_en, hg} = 2'b00;
    tk(2);
    hg = 1'b1;
    acc = 1'b0;
    for (i = 0; i < 4; i++) begin
      tk();
      acc |= hev;
    end
    chk({15'h0, acc}, 16'h0000);
    // both gates
    {hg, ev_en} = 2'b01;
    tk();
    sg = 1'b1;
    tk(3);
    chk({15'h0, igs}, 16'h0000);
    hg = 1'b1;
    wt(0, 1'b1, 3);
    chk({15'h0, hev}, 16'h0000);
    hg = 1'b0;
    tk(3);
    chk({15'h0, igs}, 16'h0001);
    sg = 1'b0;
    wt(0, 1'b0, 3);
    tk(2);
    chk({15'h0, pwm}, 16'h0000);
    // soft gate only, per mil
    hgu = 1'b0;
    sg = 1'b1;
    wt(0, 1'b1, 3);
    wt(1, 1'b1, 3 * TBC);
    chkw(waited, TBC, 2 * TBC + 8);
    tk();
    wed(3 * TBC);
    chkw(hi_w, pw(500, 1000, 4) - 2, pw(500, 1000, 4) + 2);
    wed(3 * TBC);
    chkw(lo_w, 2 * TBC - 2, 2 * TBC + 2);
    sg = 1'b0;
    wt(0, 1'b0, 3);
    tk(2);
    chk({15'h0, pwm}, 16'h0000);
    // analog word format
    do_job(`GPW_JOB_WR_DLY, 16'h0001, `GPW_ERR_NONE);
    fmt = GPW_FMT_ANALOG;
    duty = 16'h3600;
    sg = 1'b1;
    wt(1, 1'b1, 2 * TBC);
    tk();
    wed(3 * TBC);
    chkw(hi_w, pw(13824, 27648, 4) - 2, pw(13824, 27648, 4) + 2);
    wed(3 * TBC);
    chkw(lo_w, 2 * TBC - 2, 2 * TBC + 2);
    sg = 1'b0;
    tk(4);
    // clamp to full scale
    fmt = GPW_FMT_PERMIL;
    duty = 16'h07D0;
    sg = 1'b1;
    wt(1, 1'b1, 2 * TBC);
    tk();
    e0 = edges;
    tk(5 * TBC);
    chkw(edges - e0, 0, 0);
    sg = 1'b0;
    tk(4);
    // high phase below minimum pulse
    duty = 16'h00FA;
    e0 = edges;
    sg = 1'b1;
    tk(5 * TBC);
    chkw(edges - e0, 0, 0);
    sg = 1'b0;
    tk(4);
    // slow time base limits
    tbs = GPW_TB_SLOW;
    do_job(`GPW_JOB_WR_MINP, 16'h0000, `GPW_ERR_NONE);
    do_job(`GPW_JOB_WR_PER, 16'h0001, `GPW_ERR_NONE);
    do_job(`GPW_JOB_WR_MINP, 16'h0001, `GPW_ERR_MINP_RNG);
    do_job(`GPW_JOB_NONE, 16'h0000, `GPW_ERR_NONE);
    // system error
    mv = 1'b0;
    tk(2);
    chk({15'h0, ok}, 16'h0000);
    chk(sfc, `GPW_ERR_MODE);
    sg = 1'b1;
    tk(3);
    chk({15'h0, igs}, 16'h0000);
    conclude();
  end
endmodule : gated_pwm_output_channel_tb

`default_nettype wire
